/* File: pcs_rx_stat_consts.vh */
// Constants shared by the receive status and statistics block.
// Assumes one 100 MHz clock and a plain strobe register port.
//
// Contract
// RULE_01: TX idle-pattern enable selects test mode, third.
// RULE_02: Compensation FIFO under/overflow drives fault output high.
// RULE_03: Controller resets port after fault output seen.
// RULE_04: Decoder-init flag high while decoder initialising.
// RULE_05: Excess-bit-error flag high while BER excessive.
// RULE_06: Four lane-sync-locked bits, one per lane.
// RULE_07: Mismatch increment carries this cycle's mismatch count.
// RULE_08: Mismatch increment active only with check enable.
// RULE_09: Each mismatch increment is a single-cycle pulse.
// RULE_10: Mismatch valid strobe marks meaningful increments.
// RULE_11: Code violations count bad blocks and sequences.
// RULE_12: Code-violation valid strobe marks valid increments.
// RULE_13: Separate header-error increment for every lane.
// RULE_14: Each lane's increment valid with its strobe.
// RULE_15: Lanes-aligned high only when all lanes deskewed.
// RULE_16: Lanes-aligned low means local fault present.
// RULE_17: Alignment-lost raised on acquisition failure or loss; acquisition failures before the first alignment are not raised.
// RULE_18: RX idle-pattern check enable, third precedence.
// RULE_19: Downstream accumulates increments in this clock domain.
`ifndef PCS_RX_STAT_CONSTS_VH
`define PCS_RX_STAT_CONSTS_VH

`define CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define ALIGN_LOSS_ADDR 8'h08
`define CTRL_RST 6'h00
`define CTRL_TX_RFI 0
`define CTRL_TX_IDLE 1
`define CTRL_TX_TEST 2
`define CTRL_RX_RESYNC 3
`define CTRL_RX_HOLD 4
`define CTRL_RX_TEST 5
`define TX_SEL_NORMAL 2'h0
`define TX_SEL_RFI 2'h1
`define TX_SEL_IDLE 2'h2
`define TX_SEL_TEST 2'h3
`define CLK_PERIOD_NS 10
`define BER_WIN_NS 125000
`define BER_WIN_CYC (`BER_WIN_NS / `CLK_PERIOD_NS)
`define BER_LIMIT 16
`define VL_LEN_MINUS1 16'h3FFF

`endif

/* File: inc_strobe.v */
// One registered increment with its valid strobe.
// Assumes the count in is fresh every clock cycle.
`timescale 1ns/1ps
`default_nettype none
module inc_strobe #(
   parameter W = 8
) (
   input wire ref_clk,
   input wire rst_n,
   input wire en,
   input wire [W-1:0] val,
   output reg [W-1:0] inc_r,
   output reg vld_r
);
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         inc_r <= {W{1'b0}};
         vld_r <= 1'b0;
      end else if (en) begin
         // Fresh count each cycle, so no value is shown twice
         inc_r <= val;
         vld_r <= 1'b1;
      end else begin
         inc_r <= {W{1'b0}};
         vld_r <= 1'b0;
      end
   end
endmodule // inc_strobe
`default_nettype wire

/* File: ber_monitor.v */
// Sync-header error rate monitor over a fixed window.
// Assumes err_cnt holds this cycle's header errors, all lanes.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_rx_stat_consts.vh"
module ber_monitor #(
   parameter integer WIN_CYC = `BER_WIN_CYC,
   parameter integer LIMIT = `BER_LIMIT,
   parameter EW = 4
) (
   input wire ref_clk,
   input wire rst_n,
   input wire active,
   input wire [EW-1:0] err_cnt,
   output reg hi_ber_r
);
   localparam integer WIN_LAST = WIN_CYC - 1;
   reg [15:0] win_r;
   reg [7:0] cnt_r;
   wire [8:0] sum = {1'b0, cnt_r} + {{(9-EW){1'b0}}, err_cnt};
   wire [7:0] cnt_nxt = sum[8] ? 8'hFF : sum[7:0];
   wire win_end = (win_r == WIN_LAST[15:0]);
   wire over = (cnt_nxt >= LIMIT[7:0]);

   always @(posedge ref_clk) begin
      if (!rst_n || !active) begin
         win_r <= 16'h0000;
         cnt_r <= 8'h00;
         hi_ber_r <= 1'b0;
      end else begin
         win_r <= win_end ? 16'h0000 : win_r + 16'h0001;
         cnt_r <= win_end ? 8'h00 : cnt_nxt;
         // Set at once, cleared by a quiet window or when active drops
         if (over)
            hi_ber_r <= 1'b1; // RULE_05
         else if (win_end)
            hi_ber_r <= 1'b0;
      end
   end
endmodule // ber_monitor
`default_nettype wire

/* File: pcs_rx_lane_status_stats.v */
// Receive lane status, alignment and statistics increments.
// Assumes datapath event inputs are synchronous to ref_clk.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_rx_stat_consts.vh"
module pcs_rx_lane_status_stats #(
   parameter LANES = 4,
   parameter HDR_W = 2,
   parameter CV_W = 4,
   parameter [15:0] VL_LEN_MINUS1 = `VL_LEN_MINUS1,
   parameter integer BER_WIN_CYC = `BER_WIN_CYC
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [LANES-1:0] lane_lock_in,
   input wire [LANES-1:0] marker_seen_in,
   input wire [LANES*HDR_W-1:0] hdr_err_in,
   input wire [CV_W-1:0] bad_block_cnt_in,
   input wire illegal_seq_in,
   input wire [7:0] mismatch_cnt_in,
   input wire fifo_under_in,
   input wire fifo_over_in,
   output reg [LANES-1:0] lane_sync_locked,
   output reg lanes_aligned,
   output reg rx_local_fault,
   output reg alignment_lost,
   output wire rx_excess_bit_error_flag,
   output reg decoder_init_state,
   output reg comp_fifo_fault,
   output wire [7:0] pattern_mismatch_inc,
   output wire pattern_mismatch_valid,
   output wire [CV_W-1:0] code_violation_inc,
   output wire code_violation_valid,
   output wire [LANES*HDR_W-1:0] lane_hdr_err_inc,
   output wire [LANES-1:0] lane_hdr_err_valid,
   output reg [1:0] tx_sel,
   output reg tx_idle_test_mode,
   output reg rx_idle_check_active
);
   localparam [1:0] AL_HUNT = 2'h0;
   localparam [1:0] AL_ACQ = 2'h1;
   localparam [1:0] AL_LOCKED = 2'h2;
   localparam DEC_INIT = 1'b0;
   localparam DEC_RUN = 1'b1;
   localparam SUM_W = HDR_W + 3;

   function [CV_W-1:0] sat_add1;
      input [CV_W-1:0] a;
      input b;
      begin
         if (&a)
            sat_add1 = a;
         else
            sat_add1 = a + {{(CV_W-1){1'b0}}, b};
      end
   endfunction

   function [SUM_W-1:0] lane_sum;
      input [LANES*HDR_W-1:0] v;
      integer i;
      begin
         lane_sum = {SUM_W{1'b0}};
         for (i = 0; i < LANES; i = i + 1)
            lane_sum = lane_sum + {3'h0, v[i*HDR_W +: HDR_W]};
      end
   endfunction

   function at_lock;
      input [1:0] st;
      begin
         at_lock = (st == AL_LOCKED);
      end
   endfunction

   function addr_is;
      input [7:0] a;
      input [7:0] want;
      begin
         addr_is = (a == want);
      end
   endfunction

   reg [5:0] ctrl_r;
   reg [7:0] loss_cnt_r;
   reg [1:0] al_state_r;
   reg [1:0] al_state_nxt;
   reg [LANES-1:0] seen_r;
   reg [LANES-1:0] seen_nxt;
   reg seen_once_r;
   reg seen_once_nxt;
   reg [15:0] period_r;
   reg [15:0] period_nxt;
   reg lost_nxt;
   reg dec_state_r;
   reg dec_state_nxt;
   reg [1:0] tx_sel_nxt;
   reg fifo_fault_nxt;
   reg [7:0] loss_cnt_nxt;
   reg [31:0] rdata_nxt;

   wire all_locked = &lane_lock_in;
   wire resync = ctrl_r[`CTRL_RX_RESYNC];
   wire hold_init = ctrl_r[`CTRL_RX_HOLD];
   wire [LANES-1:0] seen_now = seen_r | marker_seen_in;
   wire period_end = (period_r == VL_LEN_MINUS1);
   wire check_en;
   wire hi_ber;
   wire [SUM_W-1:0] hdr_sum = lane_sum(hdr_err_in);
   wire wr_ctrl = reg_wr && addr_is(reg_addr, `CTRL_ADDR);
   wire clr_loss = reg_wr && addr_is(reg_addr, `ALIGN_LOSS_ADDR);
   wire [31:0] status_word;

   // Third in line: any higher receive control masks the check
   assign check_en = ctrl_r[`CTRL_RX_TEST] & ~resync & ~hold_init; // RULE_18
   assign rx_excess_bit_error_flag = hi_ber; // RULE_05

   // Lane alignment and deskew tracking
   always @* begin
      al_state_nxt = al_state_r;
      seen_nxt = seen_now;
      seen_once_nxt = seen_once_r;
      period_nxt = period_end ? 16'h0000 : period_r + 16'h0001;
      lost_nxt = 1'b0;
      case (al_state_r)
         AL_HUNT: begin
            seen_nxt = {LANES{1'b0}};
            period_nxt = 16'h0000;
            if (all_locked && !resync)
               al_state_nxt = AL_ACQ;
         end
         AL_ACQ: begin
            if (!all_locked || resync) begin
               al_state_nxt = AL_HUNT;
               lost_nxt = seen_once_r; // RULE_17
            end else if (&seen_now) begin
               al_state_nxt = AL_LOCKED;
               seen_once_nxt = 1'b1;
               seen_nxt = {LANES{1'b0}};
               period_nxt = 16'h0000;
            end else if (period_end) begin
               // Quiet until markers were seen once on all lanes
               lost_nxt = seen_once_r; // RULE_17
               seen_nxt = {LANES{1'b0}};
            end
         end
         AL_LOCKED: begin
            if (!all_locked || resync) begin
               al_state_nxt = AL_HUNT;
               lost_nxt = 1'b1; // RULE_17
            end else if (period_end) begin
               seen_nxt = {LANES{1'b0}};
               if (!(&seen_now)) begin
                  al_state_nxt = AL_ACQ;
                  lost_nxt = 1'b1; // RULE_17
               end
            end
         end
         default: begin
            al_state_nxt = AL_HUNT;
            seen_nxt = {LANES{1'b0}};
         end
      endcase
   end

   // Decoder init state follows alignment and error rate
   always @* begin
      dec_state_nxt = dec_state_r;
      case (dec_state_r)
         DEC_INIT:
            if (at_lock(al_state_nxt) && !hi_ber && !hold_init)
               dec_state_nxt = DEC_RUN;
         DEC_RUN:
            if (!at_lock(al_state_nxt) || hi_ber || hold_init)
               dec_state_nxt = DEC_INIT;
         default:
            dec_state_nxt = DEC_INIT;
      endcase
   end

   // Transmit control precedence
   always @* begin
      if (ctrl_r[`CTRL_TX_RFI])
         tx_sel_nxt = `TX_SEL_RFI;
      else if (ctrl_r[`CTRL_TX_IDLE])
         tx_sel_nxt = `TX_SEL_IDLE;
      else if (ctrl_r[`CTRL_TX_TEST])
         tx_sel_nxt = `TX_SEL_TEST; // RULE_01
      else
         tx_sel_nxt = `TX_SEL_NORMAL;
   end

   // Sticky: only a reset of the port clears the fault
   always @* begin
      fifo_fault_nxt = comp_fifo_fault;
      if (fifo_under_in || fifo_over_in)
         fifo_fault_nxt = 1'b1; // RULE_02
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         al_state_r <= AL_HUNT;
         seen_r <= {LANES{1'b0}};
         seen_once_r <= 1'b0;
         period_r <= 16'h0000;
         dec_state_r <= DEC_INIT;
         lane_sync_locked <= {LANES{1'b0}};
         lanes_aligned <= 1'b0;
         rx_local_fault <= 1'b1;
         alignment_lost <= 1'b0;
         decoder_init_state <= 1'b1;
         comp_fifo_fault <= 1'b0;
         tx_sel <= `TX_SEL_NORMAL;
         tx_idle_test_mode <= 1'b0;
         rx_idle_check_active <= 1'b0;
      end else begin
         al_state_r <= al_state_nxt;
         seen_r <= seen_nxt;
         seen_once_r <= seen_once_nxt;
         period_r <= period_nxt;
         dec_state_r <= dec_state_nxt;
         lane_sync_locked <= lane_lock_in; // RULE_06
         lanes_aligned <= at_lock(al_state_nxt); // RULE_15
         rx_local_fault <= !at_lock(al_state_nxt); // RULE_16
         alignment_lost <= lost_nxt; // RULE_17
         decoder_init_state <= (dec_state_nxt == DEC_INIT); // RULE_04
         comp_fifo_fault <= fifo_fault_nxt; // RULE_02
         tx_sel <= tx_sel_nxt;
         tx_idle_test_mode <= (tx_sel_nxt == `TX_SEL_TEST); // RULE_01
         rx_idle_check_active <= check_en;
      end
   end

   // Mismatch counts are dropped while checking is off
   inc_strobe #(
      .W(8)
   ) u_mismatch (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .en(check_en), // RULE_08
      .val(mismatch_cnt_in), // RULE_07
      .inc_r(pattern_mismatch_inc), // RULE_09
      .vld_r(pattern_mismatch_valid) // RULE_10
   );

   inc_strobe #(
      .W(CV_W)
   ) u_code_viol (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .en(lanes_aligned), // RULE_12
      .val(sat_add1(bad_block_cnt_in, illegal_seq_in)), // RULE_11
      .inc_r(code_violation_inc),
      .vld_r(code_violation_valid)
   );

   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         inc_strobe #(
            .W(HDR_W)
         ) u_hdr (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .en(lane_lock_in[g]), // RULE_14
            .val(hdr_err_in[g*HDR_W +: HDR_W]), // RULE_13
            .inc_r(lane_hdr_err_inc[g*HDR_W +: HDR_W]),
            .vld_r(lane_hdr_err_valid[g])
         );
      end
   endgenerate

   // Error rate only means something once every lane has lock
   ber_monitor #(
      .WIN_CYC(BER_WIN_CYC),
      .LIMIT(`BER_LIMIT),
      .EW(SUM_W)
   ) u_ber (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .active(all_locked),
      .err_cnt(hdr_sum),
      .hi_ber_r(hi_ber)
   );

   // Status word is read-only; writes to it are dropped
   assign status_word = {19'h0, al_state_r, rx_idle_check_active, tx_sel,
      comp_fifo_fault, decoder_init_state, hi_ber, lanes_aligned,
      lane_sync_locked[3:0]};

   // A loss in the clearing cycle still counts
   always @* begin
      if (alignment_lost) begin
         if (clr_loss)
            loss_cnt_nxt = 8'h01;
         else if (loss_cnt_r == 8'hFF)
            loss_cnt_nxt = loss_cnt_r; // Saturates rather than wrap to zero
         else
            loss_cnt_nxt = loss_cnt_r + 8'h01;
      end else if (clr_loss) begin
         loss_cnt_nxt = 8'h00;
      end else begin
         loss_cnt_nxt = loss_cnt_r;
      end
   end

   // Read data stand for one cycle only, zero otherwise
   always @* begin
      rdata_nxt = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `CTRL_ADDR:
               rdata_nxt = {26'h0, ctrl_r};
            `STATUS_ADDR:
               rdata_nxt = status_word;
            `ALIGN_LOSS_ADDR:
               rdata_nxt = {24'h0, loss_cnt_r};
            default:
               rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Register port
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_r <= `CTRL_RST;
         loss_cnt_r <= 8'h00;
         reg_rdata <= 32'h00000000;
      end else begin
         if (wr_ctrl)
            ctrl_r <= reg_wdata[5:0];
         loss_cnt_r <= loss_cnt_nxt; // RULE_17
         reg_rdata <= rdata_nxt;
      end
   end
endmodule // pcs_rx_lane_status_stats
`default_nettype wire

/* File: stats_sink.sv */
// Far-side statistics consumer: accumulates increments, asks for reset.
// Assumes it shares ref_clk and rst_n with the block.
`timescale 1ns/1ps
`default_nettype none
module stats_sink (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] mm_inc,
   input wire logic mm_vld,
   input wire logic [3:0] cv_inc,
   input wire logic cv_vld,
   input wire logic [7:0] hdr_inc,
   input wire logic [3:0] hdr_vld,
   input wire logic fifo_fault,
   output var logic [31:0] mm_tot,
   output var logic [31:0] cv_tot,
   output var logic [31:0] hdr_tot,
   output var logic port_rst_req
);
   logic [31:0] hdr_sum;
   always @* begin
      hdr_sum = 32'h0;
      for (int i = 0; i < 4; i++)
         if (hdr_vld[i]) hdr_sum += hdr_inc[2*i+:2];
   end
   // Wide wrapping totals kept in this clock domain
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         mm_tot <= 32'h0;
         cv_tot <= 32'h0;
         hdr_tot <= 32'h0;
         port_rst_req <= 1'h0;
      end else begin
         if (mm_vld) mm_tot <= mm_tot + mm_inc;
         if (cv_vld) cv_tot <= cv_tot + cv_inc;
         hdr_tot <= hdr_tot + hdr_sum;
         port_rst_req <= fifo_fault;
      end
   end
endmodule // stats_sink
`default_nettype wire

/* File: pcs_rx_lane_status_stats_monitor.sv */
// Assertion checker for the receive status block, ports only.
// Assumes one clock domain; bound in below.
`timescale 1ns/1ps
`default_nettype none
module pcs_rx_stat_checker #(
   parameter LANES = 4,
   parameter HDR_W = 2,
   parameter CV_W = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [LANES-1:0] lane_lock_in,
   input wire logic [LANES*HDR_W-1:0] hdr_err_in,
   input wire logic [CV_W-1:0] bad_block_cnt_in,
   input wire logic illegal_seq_in,
   input wire logic [7:0] mismatch_cnt_in,
   input wire logic fifo_under_in,
   input wire logic fifo_over_in,
   input wire logic [LANES-1:0] lane_sync_locked,
   input wire logic lanes_aligned,
   input wire logic rx_local_fault,
   input wire logic alignment_lost,
   input wire logic comp_fifo_fault,
   input wire logic decoder_init_state,
   input wire logic rx_idle_check_active,
   input wire logic [7:0] pattern_mismatch_inc,
   input wire logic pattern_mismatch_valid,
   input wire logic [CV_W-1:0] code_violation_inc,
   input wire logic code_violation_valid,
   input wire logic [LANES*HDR_W-1:0] lane_hdr_err_inc,
   input wire logic [LANES-1:0] lane_hdr_err_valid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire [CV_W:0] cv_sum = bad_block_cnt_in + illegal_seq_in;
   wire [CV_W-1:0] cv_sat = cv_sum[CV_W] ? {CV_W{1'h1}} : cv_sum[CV_W-1:0];
   wire [LANES*HDR_W-1:0] hmask;
   for (genvar g = 0; g < LANES; g++) begin : g_mask
      assign hmask[g*HDR_W+:HDR_W] = {HDR_W{lane_hdr_err_valid[g]}};
   end
   property p_mm_inc;
      pattern_mismatch_valid |->
         pattern_mismatch_inc == $past(mismatch_cnt_in);
   endproperty
   a_mm_inc: assert property (p_mm_inc) else $error("mm inc");
   property p_mm_pulse;
      !pattern_mismatch_valid |-> pattern_mismatch_inc == 8'h00;
   endproperty
   a_mm_pulse: assert property (p_mm_pulse) else $error("mm idle");
   property p_cv_inc;
      code_violation_valid |-> code_violation_inc == $past(cv_sat);
   endproperty
   a_cv_inc: assert property (p_cv_inc) else $error("cv inc");
   property p_cv_vld;
      code_violation_valid |-> $past(lanes_aligned);
   endproperty
   a_cv_vld: assert property (p_cv_vld) else $error("cv valid");
   property p_hdr;
      lane_hdr_err_inc == ($past(hdr_err_in) & hmask);
   endproperty
   a_hdr: assert property (p_hdr) else $error("hdr inc");
   property p_hdr_vld;
      lane_hdr_err_valid == $past(lane_lock_in);
   endproperty
   a_hdr_vld: assert property (p_hdr_vld) else $error("hdr vld");
   property p_lock;
      lane_sync_locked == $past(lane_lock_in);
   endproperty
   a_lock: assert property (p_lock) else $error("lock copy");
   property p_fault;
      rx_local_fault != lanes_aligned;
   endproperty
   a_fault: assert property (p_fault) else $error("local fault");
   property p_fifo;
      fifo_under_in || fifo_over_in |=> comp_fifo_fault [*3];
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo fault");
   property p_lost;
      $fell(lanes_aligned) |-> alignment_lost ##1 !alignment_lost;
   endproperty
   a_lost: assert property (p_lost) else $error("align lost");
   property p_mm_gate;
      pattern_mismatch_valid == rx_idle_check_active;
   endproperty
   a_mm_gate: assert property (p_mm_gate) else $error("mm gate");
   property p_dec_init;
      !lanes_aligned |-> decoder_init_state;
   endproperty
   a_dec_init: assert property (p_dec_init) else $error("dec init");
   c_mm: cover property (pattern_mismatch_valid && pattern_mismatch_inc != 0);
   c_cv: cover property (code_violation_valid && code_violation_inc == 4'hF);
   c_lost: cover property ($fell(lanes_aligned));
endmodule // pcs_rx_stat_checker
bind pcs_rx_lane_status_stats pcs_rx_stat_checker #(.LANES(LANES),
   .HDR_W(HDR_W), .CV_W(CV_W)) chk_u (.ref_clk, .rst_n, .lane_lock_in,
   .hdr_err_in, .bad_block_cnt_in, .illegal_seq_in, .mismatch_cnt_in,
   .fifo_under_in, .fifo_over_in, .lane_sync_locked, .lanes_aligned,
   .rx_local_fault, .alignment_lost, .comp_fifo_fault, .decoder_init_state,
   .rx_idle_check_active, .pattern_mismatch_inc, .pattern_mismatch_valid,
   .code_violation_inc,
   .code_violation_valid, .lane_hdr_err_inc, .lane_hdr_err_valid);
`default_nettype wire

/* File: pcs_rx_lane_status_stats_tb.sv */
// Self-checking bench: register bus, alignment, statistics, fifo fault.
// Assumes stats_sink and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pcs_rx_lane_status_stats_tb;
   logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h00, mismatch_cnt_in = 8'h00, hdr_err_in = 8'h00;
   logic [31:0] reg_wdata = 32'h0, d;
   logic [3:0] lane_lock_in = 4'h0, marker_seen_in = 4'h0, mk_cnt = 4'h0;
   logic [3:0] bad_block_cnt_in = 4'h0;
   logic illegal_seq_in = 0, fifo_under_in = 0, fifo_over_in = 0;
   wire [31:0] reg_rdata, mm_tot, cv_tot, hdr_tot;
   wire [3:0] lane_sync_locked, lane_hdr_err_valid, code_violation_inc;
   wire [7:0] pattern_mismatch_inc, lane_hdr_err_inc;
   wire [1:0] tx_sel;
   wire lanes_aligned, rx_local_fault, alignment_lost, comp_fifo_fault;
   wire rx_excess_bit_error_flag, decoder_init_state, pattern_mismatch_valid;
   wire code_violation_valid, tx_idle_test_mode, rx_idle_check_active;
   wire port_rst_req;
   int bad_count = 0, num_checks = 0, mm_exp = 0, cv_exp = 0, hdr_exp = 0;
   int lost_n = 0, e, tx_e;
   bit rnd_on = 0, mk_on = 0, chk_en = 0, al_exp = 0;
   // Short marker period and BER window keep the run brief
   pcs_rx_lane_status_stats #(.VL_LEN_MINUS1(16'h000F), .BER_WIN_CYC(50))
      dut_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .lane_lock_in, .marker_seen_in, .hdr_err_in,
      .bad_block_cnt_in, .illegal_seq_in, .mismatch_cnt_in, .fifo_under_in,
      .fifo_over_in, .lane_sync_locked, .lanes_aligned, .rx_local_fault,
      .alignment_lost, .rx_excess_bit_error_flag, .decoder_init_state,
      .comp_fifo_fault, .pattern_mismatch_inc, .pattern_mismatch_valid,
      .code_violation_inc, .code_violation_valid, .lane_hdr_err_inc,
      .lane_hdr_err_valid, .tx_sel, .tx_idle_test_mode,
      .rx_idle_check_active);
   stats_sink sink_u (.ref_clk, .rst_n, .mm_inc(pattern_mismatch_inc),
      .mm_vld(pattern_mismatch_valid), .cv_inc(code_violation_inc),
      .cv_vld(code_violation_valid), .hdr_inc(lane_hdr_err_inc),
      .hdr_vld(lane_hdr_err_valid), .fifo_fault(comp_fifo_fault),
      .mm_tot, .cv_tot, .hdr_tot, .port_rst_req);
   always #5 ref_clk = ~ref_clk;
   // Stimulus and reference totals, both on the same edge
   always @(posedge ref_clk) begin
      mk_cnt <= mk_cnt + 4'h1;
      marker_seen_in <= (mk_on && mk_cnt == 4'h0) ? 4'hF : 4'h0;
      mismatch_cnt_in <= rnd_on ? 8'($urandom) : 8'h00;
      bad_block_cnt_in <= rnd_on ? 4'($urandom) : 4'h0;
      illegal_seq_in <= rnd_on ? 1'($urandom) : 1'h0;
      hdr_err_in <= rnd_on ? 8'($urandom) : 8'h00;
      e = bad_block_cnt_in + illegal_seq_in;
      if (chk_en) mm_exp += mismatch_cnt_in;
      if (al_exp) cv_exp += (e > 15) ? 15 : e;
      for (int i = 0; i < 4; i++)
         if (lane_lock_in[i]) hdr_exp += hdr_err_in[2*i+:2];
      if (alignment_lost === 1'h1) lost_n++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask
   task automatic do_reset;
      rst_n <= 1'h0;
      lane_lock_in <= 4'h0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'h1;
   endtask
   // Bounded wait on alignment (0) or the sink's reset request (1)
   task automatic wait_sig(input bit which);
      for (int n = 0; (which ? port_rst_req : lanes_aligned) !== 1'h1; n++)
      begin
         @(posedge ref_clk);
         #1;
         if (n > 200) begin
            bad_count++;
            wrap_up;
         end
      end
   endtask
   task automatic burst(input int n);
      #1 rnd_on = 1;
      repeat (n) @(posedge ref_clk);
      #1 rnd_on = 0;
      repeat (3) @(posedge ref_clk);
      #1 chk(mm_tot, mm_exp);
      chk(cv_tot, cv_exp);
      chk(hdr_tot, hdr_exp);
   endtask
   initial begin
      void'($urandom(70));
      do_reset;
      rd(8'h04);
      chk(d, 32'h40);
      chk(rx_local_fault, 1);
      wr(8'h04, 32'hFFFF);
      rd(8'h04);
      chk(d, 32'h40);
      rd(8'h0C);
      chk(d, 32'h0);
      $display("reset and map test done");
      for (int i = 0; i < 8; i++) begin
         wr(8'h00, 32'(i));
         tx_e = i[0] ? 1 : i[1] ? 2 : i[2] ? 3 : 0;
         @(posedge ref_clk);
         #1 chk(tx_sel, tx_e);
         chk(tx_idle_test_mode, tx_e == 3);
      end
      $display("tx precedence test done");
      wr(8'h00, 32'h20);
      lane_lock_in <= 4'hF;
      #1 mk_on = 1;
      wait_sig(0);
      chk(lane_sync_locked, 4'hF);
      chk(rx_idle_check_active, 1);
      chk(decoder_init_state, 0);
      chk(rx_local_fault, 0);
      chk_en = 1;
      al_exp = 1;
      burst(200);
      chk(rx_excess_bit_error_flag, 1);
      chk(decoder_init_state, 1);
      chk_en = 0;
      wr(8'h00, 32'h0);
      burst(30);
      $display("statistics test done");
      al_exp = 0;
      @(posedge ref_clk);
      lane_lock_in <= 4'hB;
      repeat (4) @(posedge ref_clk);
      #1 chk(lanes_aligned, 0);
      chk(lost_n, 1);
      chk(rx_excess_bit_error_flag, 0);
      rd(8'h08);
      chk(d, 32'h1);
      burst(40);
      $display("lock loss test done");
      for (int j = 0; j < 2; j++) begin
         @(posedge ref_clk);
         fifo_under_in <= (j == 0);
         fifo_over_in <= (j == 1);
         @(posedge ref_clk);
         fifo_under_in <= 1'h0;
         fifo_over_in <= 1'h0;
         wait_sig(1);
         chk(comp_fifo_fault, 1);
         @(posedge ref_clk);
         do_reset;
         #1 chk(comp_fifo_fault, 0);
      end
      $display("fifo fault test done");
      wrap_up;
   end
endmodule // pcs_rx_lane_status_stats_tb
`default_nettype wire
